/* hdl/fsp_ctrl.v */
// flash self-program control: command register, arming window, page buffer and sequencer
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "fsp_defines.vh"

module fsp_ctrl #(
  parameter [`FSP_TMR_W-1:0] PROG_CYCLES = `FSP_PROG_CYCLES
) (
  // clock and reset
  input  wire                    hclk,
  input  wire                    hresetn,
  // ahb-lite slave
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire [31:0]             hwdata,
  input  wire                    hready,
  output reg                     hreadyout,
  output reg  [31:0]             hrdata,
  output reg                     hresp,
  // cpu core
  input  wire                    store_program_instr,
  input  wire                    load_program_instr,
  input  wire [7:0]              pointer_high_byte,
  input  wire [7:0]              pointer_low_byte,
  input  wire [15:0]             data_pair,
  output reg                     cpu_stall_r,
  output reg                     fuse_data_valid_r,
  output reg  [7:0]              fuse_data_r,
  // eeprom controller
  input  wire                    eeprom_busy,
  input  wire                    eeprom_write_start,
  // fuse and lock values
  input  wire [1:0]              lock_bits,
  input  wire [7:0]              fuse_low,
  input  wire [7:0]              fuse_high,
  // flash array
  output reg                     flash_erase_r,
  output reg                     flash_prog_r,
  output reg  [`FSP_PAGE_W-1:0]  flash_page_r,
  output reg  [`FSP_WORD_W-1:0]  flash_word_r,
  output reg  [15:0]             flash_wdata_r
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ARMED = 3'h1;
  localparam [2:0] ST_RD    = 3'h2;
  localparam [2:0] ST_PUT   = 3'h3;
  localparam [2:0] ST_WAIT  = 3'h4;

  wire [15:0]             z_ptr = {pointer_high_byte, pointer_low_byte};
  wire [`FSP_WORD_W-1:0]  z_word = z_ptr[`FSP_WORD_MSB:`FSP_WORD_LSB];
  wire [`FSP_PAGE_W-1:0]  z_page = z_ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];

  reg  [4:0]              ctrl_r;
  reg  [2:0]              state_r;
  reg  [2:0]              win_cnt_r;
  reg  [`FSP_TMR_W-1:0]   tmr_r;
  reg  [`FSP_WORD_W-1:0]  idx_r;
  reg                     loading_r;
  reg                     dp_wr_r;
  reg                     dp_rd_r;
  reg  [`FSP_ADDR_MSB:0]  dp_addr_r;
  wire [15:0]             buf_rd;
  reg                     buf_wr;
  reg                     buf_clr;

  // ****************************************
  // status word
  // ****************************************
  wire [31:0]             stat_word = {29'h0000_0000, eeprom_busy, loading_r, cpu_stall_r};

  // ****************************************
  // ahb-lite slave: zero-wait writes, one wait state on reads
  // ****************************************
  // the read wait state lets a write in the previous data phase land first
  wire addr_ok = hsel && hready && htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= {(`FSP_ADDR_MSB+1){1'b0}};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      dp_wr_r <= addr_ok && hwrite;
      dp_rd_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        dp_addr_r <= haddr[`FSP_ADDR_MSB:0];
      end
      hreadyout <= !(addr_ok && !hwrite);
      if (dp_rd_r) begin
        case (dp_addr_r)
          `FSP_ADDR_CTRL: hrdata <= {27'h000_0000, ctrl_r};
          `FSP_ADDR_STAT: hrdata <= stat_word;
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire ctrl_wr = dp_wr_r && (dp_addr_r == `FSP_ADDR_CTRL);
  wire [4:0] wr_pat = hwdata[4:0];
  // only the five command patterns take effect; eeprom busy blocks them all
  reg  pat_ok;

  always @* begin
    case (wr_pat)
      `FSP_CMD_LOAD:  pat_ok = 1'b1;
      `FSP_CMD_ERASE: pat_ok = 1'b1;
      `FSP_CMD_WRITE: pat_ok = 1'b1;
      `FSP_CMD_FUSE:  pat_ok = 1'b1;
      `FSP_CMD_CLR:   pat_ok = 1'b1;
      default:        pat_ok = 1'b0;
    endcase
  end

  wire cmd_take = ctrl_wr && pat_ok && !eeprom_busy && (state_r == ST_IDLE || state_r == ST_ARMED);

  // ****************************************
  // arming window
  // ****************************************
  // three bits suffice: the store window ends at a count of three, the fuse load window at two, and a new command restarts it
  wire armed      = (state_r == ST_ARMED);
  wire store_ok   = armed && store_program_instr && !eeprom_busy && (win_cnt_r <= `FSP_STORE_WINDOW);
  wire load_ok    = armed && ctrl_r[`FSP_CTRL_FUSE] && load_program_instr && !eeprom_busy &&
                    (win_cnt_r <= `FSP_LOAD_WINDOW);
  wire store_late = armed && (win_cnt_r == `FSP_STORE_WINDOW) && !store_ok;
  wire load_late  = armed && ctrl_r[`FSP_CTRL_FUSE] && (win_cnt_r == `FSP_LOAD_WINDOW) && !load_ok;

  // ****************************************
  // fuse and lock read select
  // ****************************************
  // z bit 0 picks lock versus fuse, z bit 1 the high fuse byte
  reg  [7:0]  fuse_sel;

  always @* begin
    if (z_ptr[0]) begin
      fuse_sel = {`FSP_LOCK_PAD, lock_bits};
    end else if (z_ptr[1]) begin
      fuse_sel = fuse_high;
    end else begin
      fuse_sel = fuse_low;
    end
  end

  // ****************************************
  // page buffer write and clear
  // ****************************************
  always @* begin
    // plain load ignores z bit 0 since only the word field is used
    buf_wr  = store_ok && (ctrl_r == `FSP_CMD_LOAD);
    buf_clr = (cmd_take && (wr_pat == `FSP_CMD_CLR)) ||
              ((state_r == ST_WAIT) && (tmr_r == {`FSP_TMR_W{1'b0}}) &&
               ctrl_r[`FSP_CTRL_WRITE]) ||
              (eeprom_write_start && loading_r);
  end

  fsp_page_buf u_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clr       (buf_clr),
    .wr_en     (buf_wr),
    .wr_addr   (z_word),
    .wr_data   (data_pair),
    .rd_addr   (idx_r),
    .rd_data_r (buf_rd)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loading_r <= 1'b0;
    end else if (buf_clr) begin
      loading_r <= 1'b0;
    end else if (buf_wr) begin
      loading_r <= 1'b1;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r           <= ST_IDLE;
      ctrl_r            <= `FSP_CTRL_RESET;
      win_cnt_r         <= 3'h0;
      tmr_r             <= {`FSP_TMR_W{1'b0}};
      idx_r             <= {`FSP_WORD_W{1'b0}};
      cpu_stall_r       <= 1'b0;
      fuse_data_valid_r <= 1'b0;
      fuse_data_r       <= 8'h00;
      flash_erase_r     <= 1'b0;
      flash_prog_r      <= 1'b0;
      flash_page_r      <= {`FSP_PAGE_W{1'b0}};
      flash_word_r      <= {`FSP_WORD_W{1'b0}};
      flash_wdata_r     <= `FSP_ERASED_WORD;
    end else begin
      flash_erase_r     <= 1'b0;
      flash_prog_r      <= 1'b0;
      fuse_data_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_take) begin
            ctrl_r    <= wr_pat;
            win_cnt_r <= 3'h0;
            state_r   <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          win_cnt_r <= win_cnt_r + 3'h1;
          if (cmd_take) begin
            ctrl_r    <= wr_pat;
            win_cnt_r <= 3'h0;
          end else if (load_ok) begin
            fuse_data_valid_r <= 1'b1;
            fuse_data_r       <= fuse_sel;
            ctrl_r  <= `FSP_CTRL_RESET;
            state_r <= ST_IDLE;
          end else if (store_ok) begin
            if (ctrl_r == `FSP_CMD_ERASE) begin
              // only the page field reaches the array
              flash_page_r  <= z_page;
              flash_erase_r <= 1'b1;
              cpu_stall_r   <= 1'b1;
              tmr_r         <= PROG_CYCLES;
              state_r       <= ST_WAIT;
            end else if (ctrl_r == `FSP_CMD_WRITE) begin
              flash_page_r <= z_page;
              idx_r        <= {`FSP_WORD_W{1'b0}};
              cpu_stall_r  <= 1'b1;
              state_r      <= ST_RD;
            end else begin
              ctrl_r  <= `FSP_CTRL_RESET;
              state_r <= ST_IDLE;
            end
          end else if (store_late || load_late) begin
            ctrl_r  <= `FSP_CTRL_RESET;
            state_r <= ST_IDLE;
          end
        end
        ST_RD: begin
          state_r <= ST_PUT;
        end
        ST_PUT: begin
          flash_prog_r  <= 1'b1;
          flash_word_r  <= idx_r;
          flash_wdata_r <= buf_rd;
          idx_r         <= idx_r + {{(`FSP_WORD_W-1){1'b0}}, 1'b1};
          if (idx_r == `FSP_LAST_WORD) begin
            tmr_r   <= PROG_CYCLES;
            state_r <= ST_WAIT;
          end else begin
            state_r <= ST_RD;
          end
        end
        ST_WAIT: begin
          // enable and command bits stay up until the timer ends
          if (tmr_r == {`FSP_TMR_W{1'b0}}) begin
            ctrl_r      <= `FSP_CTRL_RESET;
            cpu_stall_r <= 1'b0;
            state_r     <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - {{(`FSP_TMR_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_r     <= ST_IDLE;
          ctrl_r      <= `FSP_CTRL_RESET;
          cpu_stall_r <= 1'b0;
        end
      endcase
    end
  end

endmodule // fsp_ctrl

/* hdl/fsp_defines.vh */
// constants for the flash self-program control block
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define FSP_ADDR_CTRL        8'h00
`define FSP_ADDR_STAT        8'h04
`define FSP_ADDR_MSB         7

// ****************************************
// control register fields
// ****************************************
`define FSP_CTRL_EN          0
`define FSP_CTRL_ERASE       1
`define FSP_CTRL_WRITE       2
`define FSP_CTRL_FUSE        3
`define FSP_CTRL_CLR         4
`define FSP_CTRL_RESET       5'h00
`define FSP_CMD_LOAD         5'h01
`define FSP_CMD_ERASE        5'h03
`define FSP_CMD_WRITE        5'h05
`define FSP_CMD_FUSE         5'h09
`define FSP_CMD_CLR          5'h11

// ****************************************
// z pointer layout and page geometry
// ****************************************
`define FSP_WORD_LSB         1
`define FSP_WORD_MSB         4
`define FSP_PAGE_LSB         5
`define FSP_PAGE_MSB         10
`define FSP_WORD_W           4
`define FSP_PAGE_W           6
`define FSP_PAGE_WORDS       16
`define FSP_LAST_WORD        4'hF
`define FSP_ERASED_WORD      16'hFFFF
`define FSP_LOCK_PAD         6'h3F

// ****************************************
// timing
// ****************************************
`define FSP_STORE_WINDOW     3'h3
`define FSP_LOAD_WINDOW      3'h2
`define FSP_CLK_MHZ          20
`define FSP_PROG_TIME_US     3700
`define FSP_PROG_CYCLES      (`FSP_PROG_TIME_US * `FSP_CLK_MHZ)
`define FSP_TMR_W            17

`endif

/* hdl/fsp_page_buf.v */
// temporary page buffer with per-word valid bits and registered read
`timescale 1ns/1ps
`include "fsp_defines.vh"

module fsp_page_buf (
  // clock and reset
  input  wire                    hclk,
  input  wire                    hresetn,
  // control
  input  wire                    clr,
  input  wire                    wr_en,
  input  wire [`FSP_WORD_W-1:0]  wr_addr,
  input  wire [15:0]             wr_data,
  input  wire [`FSP_WORD_W-1:0]  rd_addr,
  output reg  [15:0]             rd_data_r
);

  reg [15:0]                 mem [0:`FSP_PAGE_WORDS-1];
  reg [`FSP_PAGE_WORDS-1:0]  valid_r;

  // ****************************************
  // valid bits: clear wins so a discard is never undone
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `FSP_PAGE_WORDS; i = i + 1) begin : g_valid
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          valid_r[i] <= 1'b0;
        end else if (clr) begin
          valid_r[i] <= 1'b0;
        end else if (wr_en && (wr_addr == i)) begin
          valid_r[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always @(posedge hclk) begin
    if (wr_en && !clr) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // unloaded slots read as erased flash
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_r <= `FSP_ERASED_WORD;
    end else begin
      rd_data_r <= valid_r[rd_addr] ? mem[rd_addr] : `FSP_ERASED_WORD;
    end
  end

endmodule // fsp_page_buf

/* dv/fsp_ctrl_asserts.sv */
// port assertions for the flash self-program control block
`timescale 1ns/1ps
`include "fsp_defines.vh"

module fsp_ctrl_asserts #(
  parameter [`FSP_TMR_W-1:0] PROG_CYCLES = `FSP_PROG_CYCLES
) (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // inputs seen
  input wire        store_program_instr,
  input wire        load_program_instr,
  input wire [7:0]  pointer_low_byte,
  input wire        eeprom_busy,
  input wire [1:0]  lock_bits,
  input wire [7:0]  fuse_low,
  input wire [7:0]  fuse_high,
  // outputs watched
  input wire [31:0] hrdata,
  input wire        cpu_stall_r,
  input wire        fuse_data_valid_r,
  input wire [7:0]  fuse_data_r,
  input wire        flash_erase_r,
  input wire        flash_prog_r,
  input wire [3:0]  flash_word_r
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_erase_cause; flash_erase_r |-> $past(store_program_instr) && !$past(eeprom_busy); endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase pulse without accepted store");
  property p_erase_stall; flash_erase_r |-> cpu_stall_r ##1 cpu_stall_r [*8]; endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("cpu not held during erase");
  property p_prog_stall; flash_prog_r |-> cpu_stall_r; endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("cpu not held during page write");
  property p_prog_order;
    flash_prog_r && flash_word_r != 4'hF |=> !flash_prog_r ##1 flash_prog_r && flash_word_r == $past(flash_word_r, 2) + 4'h1;
  endproperty
  a_prog_order: assert property (p_prog_order) else $error("page words out of order");
  property p_fuse_pulse; fuse_data_valid_r |=> !fuse_data_valid_r; endproperty
  a_fuse_pulse: assert property (p_fuse_pulse) else $error("fuse valid longer than one cycle");
  property p_fuse_cause; fuse_data_valid_r |-> $past(load_program_instr) && !$past(eeprom_busy); endproperty
  a_fuse_cause: assert property (p_fuse_cause) else $error("fuse read without accepted load");
  property p_fuse_value;
    fuse_data_valid_r |-> fuse_data_r == ($past(pointer_low_byte[0]) ? {6'h3F, $past(lock_bits)} :
                                          $past(pointer_low_byte[1]) ? $past(fuse_high) : $past(fuse_low));
  endproperty
  a_fuse_value: assert property (p_fuse_value) else $error("wrong fuse or lock byte");
  property p_rsvd; hrdata[31:5] == 27'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read bits set");
endmodule // fsp_ctrl_asserts

bind fsp_ctrl fsp_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_fsp_chk (
  .hclk, .hresetn, .store_program_instr, .load_program_instr, .pointer_low_byte, .eeprom_busy, .lock_bits,
  .fuse_low, .fuse_high, .hrdata, .cpu_stall_r, .fuse_data_valid_r, .fuse_data_r, .flash_erase_r,
  .flash_prog_r, .flash_word_r
);

/* dv/fsp_cpu_model.sv */
// cpu core model issuing store and load strobes after a chosen delay
`timescale 1ns/1ps

module fsp_cpu_model (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // request from the bench
  input  wire        go,
  input  wire        is_load,
  input  wire [2:0]  dly,
  input  wire [15:0] z_in,
  input  wire [15:0] d_in,
  // strobes and operands
  output reg         store_program_instr,
  output reg         load_program_instr,
  output reg  [7:0]  pointer_high_byte,
  output reg  [7:0]  pointer_low_byte,
  output reg  [15:0] data_pair
);
  reg       armed_r;
  reg [2:0] cnt_r;

  // operands toggle between strobes so stale sampling cannot pass by luck
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r <= 1'b0;
      cnt_r <= 3'h0;
      store_program_instr <= 1'b0;
      load_program_instr <= 1'b0;
      {pointer_high_byte, pointer_low_byte} <= 16'h0;
      data_pair <= 16'h0;
    end else begin
      store_program_instr <= 1'b0;
      load_program_instr <= 1'b0;
      {pointer_high_byte, pointer_low_byte} <= ~{pointer_high_byte, pointer_low_byte};
      data_pair <= ~data_pair;
      if (go ? dly == 3'h0 : armed_r && cnt_r == 3'h0) begin
        armed_r <= 1'b0;
        store_program_instr <= !is_load;
        load_program_instr <= is_load;
        {pointer_high_byte, pointer_low_byte} <= z_in;
        data_pair <= d_in;
      end else if (go) begin
        armed_r <= 1'b1;
        cnt_r <= dly - 3'h1;
      end else if (armed_r) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule // fsp_cpu_model

/* dv/test_flash_self_program_control.sv */
// self-checking bench for the flash self-program control block
`timescale 1ns/1ps

module test_flash_self_program_control;
  reg         hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, go = 1'b0, is_load = 1'b0;
  reg         eeprom_busy = 1'b0, eeprom_write_start = 1'b0;
  reg  [1:0]  htrans = 2'h0, lock_bits = 2'h0;
  reg  [2:0]  dly = 3'h0;
  reg  [7:0]  fuse_low = 8'h0, fuse_high = 8'h0;
  reg  [15:0] z_in = 16'h0, d_in = 16'h0, rnd = 16'h002D, v, z;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  reg  [15:0] got_w [0:15];
  reg  [5:0]  got_pg;
  wire        hreadyout, hresp, store_program_instr, load_program_instr;
  wire        cpu_stall_r, fuse_data_valid_r, flash_erase_r, flash_prog_r;
  wire [31:0] hrdata;
  wire [7:0]  pointer_high_byte, pointer_low_byte, fuse_data_r;
  wire [15:0] data_pair, flash_wdata_r;
  wire [5:0]  flash_page_r;
  wire [3:0]  flash_word_r;
  integer     n_mismatch = 0, checks_done = 0, cyc = 0, n_ers = 0, n_prg = 0, n_fus = 0, i, n0;

  always #25 hclk = ~hclk;

  // short program time keeps each erase and write at a few dozen cycles
  fsp_ctrl #(.PROG_CYCLES(17'd20)) DUT (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .store_program_instr, .load_program_instr, .pointer_high_byte,
    .pointer_low_byte, .data_pair, .cpu_stall_r, .fuse_data_valid_r, .fuse_data_r, .eeprom_busy,
    .eeprom_write_start, .lock_bits, .fuse_low, .fuse_high, .flash_erase_r, .flash_prog_r,
    .flash_page_r, .flash_word_r, .flash_wdata_r
  );
  fsp_cpu_model u_cpu (
    .hclk, .hresetn, .go, .is_load, .dly, .z_in, .d_in, .store_program_instr, .load_program_instr,
    .pointer_high_byte, .pointer_low_byte, .data_pair
  );

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (flash_erase_r === 1'b1) n_ers <= n_ers + 1;
    if (flash_erase_r === 1'b1 || flash_prog_r === 1'b1) got_pg <= flash_page_r;
    if (flash_prog_r === 1'b1) n_prg <= n_prg + 1;
    if (flash_prog_r === 1'b1) got_w[flash_word_r] <= flash_wdata_r;
    if (fuse_data_valid_r === 1'b1) n_fus <= n_fus + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [31:0] exp_ctrl(input [4:0] c);
    case (c)
      5'h01, 5'h03, 5'h05, 5'h09, 5'h11: exp_ctrl = {27'h0, c};
      default: exp_ctrl = 32'h0;
    endcase
  endfunction
  function [7:0] exp_fuse(input [1:0] zb);
    exp_fuse = zb[0] ? {6'h3F, lock_bits} : (zb[1] ? fuse_high : fuse_low);
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task cmd(input [4:0] c, input [15:0] zz, input [15:0] d, input [2:0] dl, input ld);
    begin
      ahb(1'b1, 8'h00, {27'h0, c});
      go <= 1'b1;
      is_load <= ld;
      dly <= dl;
      z_in <= zz;
      d_in <= d;
      @(posedge hclk);
      go <= 1'b0;
      repeat (8) @(posedge hclk);
      if (cpu_stall_r === 1'b1) begin
        ahb(1'b0, 8'h00, 32'h0);
        chk(q, {27'h0, c});
      end
      while (cpu_stall_r !== 1'b0) @(posedge hclk);
    end
  endtask
  task page_chk(input [1:0] mode);
    integer k, m0;
    reg [3:0] s;
    reg [5:0] pg;
    reg [15:0] ew [0:15];
    begin
      rnd = lfsr(rnd);
      s = rnd[3:0];
      pg = rnd[9:4];
      for (k = 0; k < 16; k++) ew[k] = 16'hFFFF;
      for (k = 0; k < 15; k++) begin
        rnd = lfsr(rnd);
        ew[k[3:0] ^ s] = rnd;
        cmd(5'h01, {5'h0, pg, k[3:0] ^ s, rnd[0]}, rnd, rnd[2] ? 3'h2 : {2'h0, rnd[1]}, 1'b0);
      end
      ahb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h2);
      m0 = n_ers;
      rnd = lfsr(rnd);
      cmd(5'h03, {rnd[15:11], pg, rnd[4:0]}, ~rnd, 3'h2, 1'b0);
      chk(n_ers - m0, 1);
      chk(got_pg, pg);
      if (mode == 2'h1) begin
        eeprom_write_start <= 1'b1;
        @(posedge hclk);
        eeprom_write_start <= 1'b0;
      end
      if (mode == 2'h2) ahb(1'b1, 8'h00, 32'h11);
      if (mode != 2'h0) for (k = 0; k < 16; k++) ew[k] = 16'hFFFF;
      repeat (6) @(posedge hclk);
      m0 = n_prg;
      cmd(5'h05, {5'h0, pg, 5'h0}, rnd, 3'h1, 1'b0);
      chk(n_prg - m0, 16);
      chk(got_pg, pg);
      for (k = 0; k < 16; k++) chk(got_w[k], ew[k]);
    end
  endtask

  task tally_and_finish;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    fuse_low <= 8'hA5;
    fuse_high <= 8'h3C;
    lock_bits <= 2'h2;
    ahb(1'b1, 8'h08, 32'hFFFFFFFF);
    ahb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      v = (i < 5) ? {rnd[15:5], 5'h01 | (5'h01 << i)} : rnd;
      ahb(1'b1, 8'h00, {rnd, v});
      ahb(1'b0, 8'h00, 32'h0);
      chk(q, exp_ctrl(v[4:0]));
      repeat (6) @(posedge hclk);
      ahb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
    end
    eeprom_busy <= 1'b1;
    ahb(1'b1, 8'h00, 32'h1);
    ahb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    eeprom_busy <= 1'b0;
    for (i = 0; i < 3; i++) page_chk(i[1:0]);
    for (i = 0; i < 3; i++) begin
      n0 = n_fus;
      z = (i == 2) ? 16'h3 : i[15:0];
      cmd(5'h09, z, 16'h0, {2'h0, i[0]}, 1'b1);
      chk(n_fus - n0, 1);
      chk(fuse_data_r, exp_fuse(z[1:0]));
    end
    n0 = n_ers;
    cmd(5'h03, 16'h0, 16'h0, 3'h3, 1'b0);
    chk(n_ers - n0, 0);
    n0 = n_fus;
    cmd(5'h09, 16'h1, 16'h0, 3'h2, 1'b1);
    chk(n_fus - n0, 0);
    tally_and_finish;
  end
endmodule // test_flash_self_program_control
